// file: hw/dma_seq_pkg.sv
package dma_seq_pkg;
	localparam int NUM_CH    = 4;
	localparam int CNT_W     = 16;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 6;
	// register word indices (byte address = index * 4)
	localparam logic [ADDR_W-1:0] CTRL0_IDX  = 6'h00;  // channel_control, one per channel
	localparam logic [ADDR_W-1:0] COUNT0_IDX = 6'h04;  // transfer_count, one per channel
	localparam logic [ADDR_W-1:0] GLOBAL_IDX = 6'h08;  // global_operation_control
	localparam logic [ADDR_W-1:0] STATE_IDX  = 6'h09;  // arbiter state (read only)
	// channel_control fields
	localparam int CC_EN    = 0;
	localparam int CC_TEF   = 1;
	localparam int CC_IRQE  = 2;
	localparam int CC_BURST = 4;
	localparam int CC_SENSE = 5;
	localparam int CC_SRC_LO = 8;
	localparam int CC_SRC_W  = 4;
	// global_operation_control fields
	localparam int GC_MEN  = 0;
	localparam int GC_NONMASKABLE_ABORT_FLAG = 1;
	localparam int GC_AEF  = 2;
	localparam int GC_PRLO = 8;
	localparam int PRIO_W  = 2;
	// request source encodings
	localparam logic [3:0] SRC_AUTO   = 4'h0;
	localparam logic [3:0] SRC_EXT_MD = 4'h2;
	localparam logic [3:0] SRC_EXT_DM = 4'h3;
	localparam logic [3:0] SRC_SER0RX = 4'h4;
	localparam logic [3:0] SRC_SER0TX = 4'h5;
	localparam logic [3:0] SRC_SER1RX = 4'h6;
	localparam logic [3:0] SRC_SER1TX = 4'h7;
	localparam logic [3:0] SRC_TMR0   = 4'h8;
	localparam logic [3:0] SRC_TMR3   = 4'hB;
	// priority modes
	localparam logic [1:0] PRIO_FIX0 = 2'h0;
	localparam logic [1:0] PRIO_FIX1 = 2'h1;
	localparam logic [1:0] PRIO_RR   = 2'h2;
	localparam logic [1:0] PRIO_PIN  = 2'h3;
	// priority order packed highest first, 2 bits per channel
	localparam logic [7:0] ORDER_0321 = 8'h39;  // 0,3,2,1
	localparam logic [7:0] ORDER_1320 = 8'h78;  // 1,3,2,0
	localparam logic [7:0] ORDER_3210 = 8'hE4;  // 3,2,1,0
	localparam int UNIT_CYCLES = 2;  // cycles one unit occupies the bus
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MOVE = 3'b010,
		ST_DONE = 3'b100
	} seq_state_t;
endpackage

// file: hw/dma_channel_sequencer_arbiter.sv
// Behaviour
// - channel runs only with enable, master enable set and end, nmi, address flags clear
// - each accepted request moves one unit and decrements its count by one
// - count reaching zero ends normally; end irq raised when irq enable set
// - address error or nonmaskable interrupt aborts the unit in progress
// - clearing channel enable or master enable aborts transfers
// - auto mode with sense select 0 requests internally as soon as the channel is permitted; with sense 1 it waits for a falling edge
// - each channel has its own four bit request source select
// - sense select 0 detects low level, 1 detects falling edge of external request
// - external encodings 0000 dual, 0010 memory to device, 0011 device to memory
// - 0100-0111 serial rx/tx channels 0,1; 1000-1011 timer channels 0-3
// - serial sources run cycle steal only; timer sources burst or cycle steal
// - on-chip request withdrawn at first unit (cycle steal) or last unit (burst)
// - requests honoured even if requester is not source or destination
// - fixed 00 ranks 0,3,2,1; fixed 01 ranks 1,3,2,0
// - round robin moves finished channel to bottom, others keep relative order
// - round robin order after reset is 0,3,2,1
// - pin round robin swaps only channels 0 and 1; 2 and 3 fixed
// - pin round robin order after reset is 3,2,1,0
// - finishing channel already lowest leaves order unchanged
// - requests during a unit wait; next choice uses the updated order
// - priority field 10 is round robin, 11 is pin round robin
// - end flag set on normal completion only; cleared by read 1 then write 0
`timescale 1ns/1ps
module dma_channel_sequencer_arbiter
	import dma_seq_pkg::*;
#(
	parameter int UNITS = UNIT_CYCLES
) (
	input  wire logic               CLOCK,            // system clock, 20 MHz
	input  wire logic               RST_B,            // synchronous reset, active low
	input  wire logic [ADDR_W-1:0]  AVS_ADDRESS,      // word index
	input  wire logic               AVS_READ,         // read strobe
	input  wire logic               AVS_WRITE,        // write strobe
	input  wire logic [DATA_W-1:0]  AVS_WRITEDATA,    // write data
	input  wire logic [3:0]         AVS_BYTEENABLE,   // byte lanes
	output logic      [DATA_W-1:0]  AVS_READDATA,     // read data
	output logic                    AVS_WAITREQUEST,  // stall, straight from a flop
	input  wire logic [NUM_CH-1:0]  EXT_REQUEST_N,    // external requests, active low pins
	input  wire logic [1:0]         SERIAL_RX_FULL_REQ,  // serial port receive full
	input  wire logic [1:0]         SERIAL_TX_EMPTY_REQ, // serial port transmit empty
	input  wire logic [3:0]         TIMER_MATCH_REQ,  // timer compare match pulses
	input  wire logic               NMI_EVENT,        // nonmaskable interrupt pulse
	input  wire logic               ADDR_ERROR,       // address error pulse from bus unit
	output logic [NUM_CH-1:0]       EXT_ACKNOWLEDGE,  // acknowledge for single address
	output logic [NUM_CH-1:0]       UNIT_GRANT,       // channel owning the current unit
	output logic                    UNIT_DIR_TO_DEV,  // single address memory to device
	output logic [NUM_CH-1:0]       TRANSFER_END_IRQ  // per channel end interrupt
);
	logic [15:0]         ctrl_r   [NUM_CH];
	logic [CNT_W-1:0]    count_r  [NUM_CH];
	logic                men_r, nonmaskable_abort_flag_r, aef_r;
	logic [PRIO_W-1:0]   prio_r, prio_last_r;
	logic [7:0]          order_r, order_nxt;
	logic [NUM_CH-1:0]   tef_seen_r, aef_seen_r, nmi_seen_r;
	logic [NUM_CH-1:0]   ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_edge_r;
	logic [NUM_CH-1:0]   mod_pend_r;
	logic [NUM_CH-1:0]   permit, req, unit_end_ch;
	seq_state_t          state_r;
	logic [1:0]          cur_r;
	logic [$clog2(UNITS+1)-1:0] cyc_r;
	logic                wr_ok, rd_ok, abort_cur, unit_last, gnt_found;
	logic [1:0]          gnt_ch;
	logic [DATA_W-1:0]   rdata_r;

	assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;
	assign rd_ok = AVS_READ & ~AVS_WAITREQUEST;

	// one wait state per access; low for the single cycle in which the access is taken
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ext_s1_r <= '1;
			ext_s2_r <= '1;
			ext_s3_r <= '1;
			ext_lvl_r <= '1;
		end else begin
			ext_s1_r <= EXT_REQUEST_N;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			for (int i = 0; i < NUM_CH; i++) begin
				if (ext_s2_r[i] == ext_s3_r[i])
					ext_lvl_r[i] <= ext_s3_r[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic [3:0] src;
			logic       on_chip, mod_in, ext_mode, edge_fall;
			assign src = ctrl_r[g][CC_SRC_LO +: CC_SRC_W];
			assign ext_mode = (src == SRC_AUTO) || (src == SRC_EXT_MD) || (src == SRC_EXT_DM);
			assign on_chip = (src >= SRC_SER0RX) && (src <= SRC_TMR3);
			always_comb begin
				unique case (src)
					SRC_SER0RX: mod_in = SERIAL_RX_FULL_REQ[0];
					SRC_SER0TX: mod_in = SERIAL_TX_EMPTY_REQ[0];
					SRC_SER1RX: mod_in = SERIAL_RX_FULL_REQ[1];
					SRC_SER1TX: mod_in = SERIAL_TX_EMPTY_REQ[1];
					default:    mod_in = (src >= SRC_TMR0 && src <= SRC_TMR3) ?
						TIMER_MATCH_REQ[src[1:0]] : 1'b0;
				endcase
			end
			assign edge_fall = ext_lvl_r[g] & ~(ext_s2_r[g] & ext_s3_r[g]) &
				(ext_s2_r[g] == ext_s3_r[g]);
			// permission gate
			assign permit[g] = ctrl_r[g][CC_EN] & men_r & ~ctrl_r[g][CC_TEF] & ~nonmaskable_abort_flag_r &
				~aef_r;
			// edge latch and on-chip pending, cleared when consumed
			always_ff @(posedge CLOCK) begin
				if (!RST_B) begin
					ext_edge_r[g] <= 1'b0;
					mod_pend_r[g] <= 1'b0;
				end else begin
					if (edge_fall)
						ext_edge_r[g] <= 1'b1;
					else if (unit_end_ch[g])
						ext_edge_r[g] <= 1'b0;
					// withdrawal point depends on bus mode; serial forces cycle steal
					if (on_chip && mod_in)
						mod_pend_r[g] <= 1'b1;
					else if (unit_end_ch[g] && (!ctrl_r[g][CC_BURST] || src < SRC_TMR0 ||
						unit_last))
						mod_pend_r[g] <= 1'b0;
				end
			end
			// requester need not be source or destination
			always_comb begin
				if (src == SRC_AUTO && !ctrl_r[g][CC_SENSE] && ext_lvl_r[g])
					req[g] = permit[g];
				else if (ext_mode)
					req[g] = permit[g] & (ctrl_r[g][CC_SENSE] ? ext_edge_r[g] : ~ext_lvl_r[g]);
				else
					req[g] = permit[g] & mod_pend_r[g];
			end
		end
	endgenerate

	// walk the order highest first
	always_comb begin
		gnt_found = 1'b0;
		gnt_ch = 2'd0;
		for (int k = NUM_CH - 1; k >= 0; k--) begin
			if (!gnt_found && req[order_r[2*k +: 2]]) begin
				gnt_found = 1'b1;
				gnt_ch = order_r[2*k +: 2];
			end
		end
	end

	assign abort_cur = NMI_EVENT | ADDR_ERROR | ~permit[cur_r];
	assign unit_last = count_r[cur_r] == CNT_W'(1);
	always_comb begin
		unit_end_ch = '0;
		if (state_r == ST_MOVE && cyc_r == ($clog2(UNITS+1))'(UNITS - 1) && !abort_cur)
			unit_end_ch[cur_r] = 1'b1;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			state_r <= ST_IDLE;
			cur_r <= 2'd0;
			cyc_r <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: if (gnt_found) begin
					state_r <= ST_MOVE;
					cur_r <= gnt_ch;
					cyc_r <= '0;
				end
				ST_MOVE: if (abort_cur) begin
					state_r <= ST_IDLE;
				end else if (unit_end_ch[cur_r]) begin
					state_r <= ST_DONE;
				end else begin
					cyc_r <= cyc_r + 1'b1;
				end
				ST_DONE: state_r <= ST_IDLE;
			endcase
		end
	end

	// rotation: finished channel moves to bottom; in pin mode only channels 0 and 1 move
	always_comb begin
		logic [7:0] rest;
		int         n;
		rest = '0;
		n = 0;
		order_nxt = order_r;
		if (prio_r == PRIO_RR) begin
			for (int k = NUM_CH - 1; k >= 0; k--) begin
				if (order_r[2*k +: 2] != cur_r) begin
					rest[2*(3-n) +: 2] = order_r[2*k +: 2];
					n = n + 1;
				end
			end
			order_nxt = {rest[7:2], cur_r};
		end else if (prio_r == PRIO_PIN && cur_r[1] == 1'b0) begin
			order_nxt = {order_r[7:4], cur_r ^ 2'd1, cur_r};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			order_r <= ORDER_0321;
			prio_last_r <= PRIO_FIX0;
		end else begin
			prio_last_r <= prio_r;
			if (prio_r != prio_last_r) begin
				unique case (prio_r)
					PRIO_FIX0: order_r <= ORDER_0321;
					PRIO_FIX1: order_r <= ORDER_1320;
					PRIO_RR:   order_r <= ORDER_0321;
					PRIO_PIN:  order_r <= ORDER_3210;
				endcase
			end else if (state_r == ST_DONE) begin
				order_r <= order_nxt;
			end
		end
	end

	// channel registers, counters and flags
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_r[i] <= 16'h0000;
				count_r[i] <= '0;
			end
			tef_seen_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (rd_ok && AVS_ADDRESS == CTRL0_IDX + ADDR_W'(i) && ctrl_r[i][CC_TEF])
					tef_seen_r[i] <= 1'b1;
				if (wr_ok && AVS_ADDRESS == CTRL0_IDX + ADDR_W'(i) && AVS_BYTEENABLE[0]) begin
					ctrl_r[i][7:0] <= {AVS_WRITEDATA[7:2],
						ctrl_r[i][CC_TEF] & ~(tef_seen_r[i] & ~AVS_WRITEDATA[CC_TEF]),
						AVS_WRITEDATA[CC_EN]};
					if (tef_seen_r[i] & ~AVS_WRITEDATA[CC_TEF])
						tef_seen_r[i] <= 1'b0;
				end
				if (wr_ok && AVS_ADDRESS == CTRL0_IDX + ADDR_W'(i) && AVS_BYTEENABLE[1])
					ctrl_r[i][15:8] <= {4'h0, AVS_WRITEDATA[11:8]};
				if (wr_ok && AVS_ADDRESS == COUNT0_IDX + ADDR_W'(i)) begin
					if (AVS_BYTEENABLE[0])
						count_r[i][7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						count_r[i][15:8] <= AVS_WRITEDATA[15:8];
				end
				if (unit_end_ch[i]) begin
					count_r[i] <= count_r[i] - 1'b1;
					if (count_r[i] == CNT_W'(1))
						ctrl_r[i][CC_TEF] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			men_r <= 1'b0;
			nonmaskable_abort_flag_r <= 1'b0;
			aef_r <= 1'b0;
			prio_r <= PRIO_FIX0;
			aef_seen_r <= '0;
			nmi_seen_r <= '0;
		end else begin
			if (rd_ok && AVS_ADDRESS == GLOBAL_IDX) begin
				aef_seen_r[0] <= aef_r;
				nmi_seen_r[0] <= nonmaskable_abort_flag_r;
			end
			if (wr_ok && AVS_ADDRESS == GLOBAL_IDX && AVS_BYTEENABLE[0]) begin
				men_r <= AVS_WRITEDATA[GC_MEN];
				if (nmi_seen_r[0] && !AVS_WRITEDATA[GC_NONMASKABLE_ABORT_FLAG])
					nonmaskable_abort_flag_r <= 1'b0;
				if (aef_seen_r[0] && !AVS_WRITEDATA[GC_AEF])
					aef_r <= 1'b0;
			end
			if (wr_ok && AVS_ADDRESS == GLOBAL_IDX && AVS_BYTEENABLE[1])
				prio_r <= AVS_WRITEDATA[GC_PRLO +: PRIO_W];
			// set wins over clear
			if (NMI_EVENT)
				nonmaskable_abort_flag_r <= 1'b1;
			if (ADDR_ERROR)
				aef_r <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				if (AVS_ADDRESS == CTRL0_IDX + ADDR_W'(i))
					rdata_r <= {16'h0000, ctrl_r[i]};
				if (AVS_ADDRESS == COUNT0_IDX + ADDR_W'(i))
					rdata_r <= {16'h0000, count_r[i]};
			end
			if (AVS_ADDRESS == GLOBAL_IDX)
				rdata_r <= {22'h00_0000, prio_r, 5'h00, aef_r, nonmaskable_abort_flag_r, men_r};
			if (AVS_ADDRESS == STATE_IDX)
				rdata_r <= {21'h00_0000, state_r, order_r};
		end
	end
	assign AVS_READDATA = rdata_r;

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			UNIT_GRANT <= '0;
			EXT_ACKNOWLEDGE <= '0;
			UNIT_DIR_TO_DEV <= 1'b0;
			TRANSFER_END_IRQ <= '0;
		end else begin
			UNIT_GRANT <= '0;
			EXT_ACKNOWLEDGE <= '0;
			if (state_r == ST_MOVE && !abort_cur) begin
				UNIT_GRANT[cur_r] <= 1'b1;
				EXT_ACKNOWLEDGE[cur_r] <=
					ctrl_r[cur_r][CC_SRC_LO +: CC_SRC_W] == SRC_EXT_MD ||
					ctrl_r[cur_r][CC_SRC_LO +: CC_SRC_W] == SRC_EXT_DM;
				UNIT_DIR_TO_DEV <= ctrl_r[cur_r][CC_SRC_LO +: CC_SRC_W] == SRC_EXT_MD;
			end
			for (int i = 0; i < NUM_CH; i++)
				TRANSFER_END_IRQ[i] <= ctrl_r[i][CC_TEF] & ctrl_r[i][CC_IRQE];
		end
	end

	property p_one_grant;
		@(posedge CLOCK) disable iff (!RST_B) $onehot0(UNIT_GRANT);
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("two grants");

	property p_count_dec;
		@(posedge CLOCK) disable iff (!RST_B)
			unit_end_ch[0] && !(wr_ok && AVS_ADDRESS == COUNT0_IDX) |=>
			count_r[0] == $past(count_r[0]) - 16'h0001;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented");

	property p_no_grant_blocked;
		@(posedge CLOCK) disable iff (!RST_B)
			state_r == ST_IDLE && gnt_found |-> permit[gnt_ch];
	endproperty
	a_no_grant_blocked: assert property (p_no_grant_blocked) else $error("blocked grant");

	property p_nmi_abort;
		@(posedge CLOCK) disable iff (!RST_B)
			state_r == ST_MOVE && NMI_EVENT |=> state_r == ST_IDLE ##1 !gnt_found;
	endproperty
	a_nmi_abort: assert property (p_nmi_abort) else $error("nmi did not abort");

	property p_rr_bottom;
		@(posedge CLOCK) disable iff (!RST_B)
			state_r == ST_DONE && prio_r == PRIO_RR && prio_last_r == PRIO_RR |=>
			order_r[1:0] == $past(cur_r);
	endproperty
	a_rr_bottom: assert property (p_rr_bottom) else $error("rotation wrong");

	property p_pin_fixed;
		@(posedge CLOCK) disable iff (!RST_B)
			prio_r == PRIO_PIN && prio_last_r == PRIO_PIN |=> order_r[7:4] == 4'hE;
	endproperty
	a_pin_fixed: assert property (p_pin_fixed) else $error("pin order moved");

	property p_end_flag;
		@(posedge CLOCK) disable iff (!RST_B)
			unit_end_ch[1] && count_r[1] == 16'h0001 |=> ctrl_r[1][CC_TEF];
	endproperty
	a_end_flag: assert property (p_end_flag) else $error("end flag missing");

	property p_fixed_order;
		@(posedge CLOCK) disable iff (!RST_B)
			prio_r == PRIO_FIX1 && prio_last_r == PRIO_FIX1 |=> order_r == ORDER_1320;
	endproperty
	a_fixed_order: assert property (p_fixed_order) else $error("fixed order wrong");
endmodule

// file: tb/dma_req_partner.sv
`timescale 1ns/1ps
module dma_req_partner (
	input  wire logic       clock,      // system clock
	input  wire logic [3:0] ext_ack,    // acknowledge from the block
	output logic      [3:0] ext_req_n,  // request pins, pulled up when released
	output logic      [1:0] rx_full,    // serial receive full requests
	output logic      [1:0] tx_empty,   // serial transmit empty requests
	output logic      [3:0] tmr_match   // timer match requests
);
	initial begin
		ext_req_n = 4'hF;
		rx_full   = 2'h0;
		tx_empty  = 2'h0;
		tmr_match = 4'h0;
	end
	// pin held low until the unit is acknowledged or 100 cycles pass, then left to the pull-up
	task automatic ext_req(input int ch);
		int n;
		n = 0;
		@(posedge clock);
		ext_req_n[ch] <= 1'b0;
		while (ext_ack[ch] !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		ext_req_n[ch] <= 1'b1;
	endtask
	// one-cycle pulse from the on-chip source picked by the select code
	task automatic chip_req(input logic [3:0] src);
		@(posedge clock);
		if (src < 4'h8) begin
			if (src[0]) tx_empty[src[1]] <= 1'b1;
			else rx_full[src[1]] <= 1'b1;
		end else begin
			tmr_match[src[1:0]] <= 1'b1;
		end
		@(posedge clock);
		rx_full   <= 2'h0;
		tx_empty  <= 2'h0;
		tmr_match <= 4'h0;
	endtask
endmodule

// file: tb/dma_channel_sequencer_arbiter_tb_top.sv
`timescale 1ns/1ps
module dma_channel_sequencer_arbiter_tb_top import dma_seq_pkg::*;;
	logic              clock = 1'b0;
	logic              rst_b = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [DATA_W-1:0] avs_readdata;
	logic [DATA_W-1:0] rd;
	logic              avs_waitrequest;
	logic              nmi = 1'b0;
	logic              aerr = 1'b0;
	logic              dir;
	logic              dir_seen;
	logic [3:0]        ext_req_n, ext_ack, grant, end_irq, tmr, ack_seen, prev_g;
	logic [1:0]        rx, tx;
	logic [3:0]        gq[$];
	int                num_errors = 0;
	int                total_checks = 0;

	always #25 clock = ~clock;

	dma_channel_sequencer_arbiter #(.UNITS(2)) u_dut (
		.CLOCK(clock), .RST_B(rst_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'h3),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.EXT_REQUEST_N(ext_req_n), .SERIAL_RX_FULL_REQ(rx), .SERIAL_TX_EMPTY_REQ(tx),
		.TIMER_MATCH_REQ(tmr), .NMI_EVENT(nmi), .ADDR_ERROR(aerr),
		.EXT_ACKNOWLEDGE(ext_ack), .UNIT_GRANT(grant), .UNIT_DIR_TO_DEV(dir),
		.TRANSFER_END_IRQ(end_irq)
	);

	dma_req_partner u_partner (
		.clock(clock), .ext_ack(ext_ack), .ext_req_n(ext_req_n),
		.rx_full(rx), .tx_empty(tx), .tmr_match(tmr)
	);

	// log each new unit grant; units of one channel are split by idle cycles
	always @(posedge clock) begin
		if (!rst_b) begin
			gq.delete();
			prev_g   <= 4'h0;
			ack_seen <= 4'h0;
			dir_seen <= 1'b0;
		end else begin
			if (grant !== 4'h0 && grant !== prev_g) gq.push_back(grant);
			prev_g   <= grant;
			ack_seen <= ack_seen | ext_ack;
			dir_seen <= dir_seen | dir;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
	endtask

	task automatic settle(input int n);
		int k;
		k = 0;
		while (gq.size() < n && k < 400) begin
			@(posedge clock);
			k++;
		end
		repeat (30) @(posedge clock);
	endtask

	function automatic logic [15:0] seq();
		logic [15:0] s;
		s = '0;
		foreach (gq[i]) s = {s[11:0], gq[i]};
		return s;
	endfunction

	// mode is set before master enable so that all channels compete from the start
	task automatic run(input logic [3:0] chans, input logic [DATA_W-1:0] cc, gc,
			input logic [15:0] cnt, input int n);
		do_reset();
		for (int c = 0; c < NUM_CH; c++) begin
			if (chans[c]) begin
				bus(1'b1, COUNT0_IDX + ADDR_W'(c), {16'h0000, cnt});
				bus(1'b1, CTRL0_IDX + ADDR_W'(c), cc);
			end
		end
		bus(1'b1, GLOBAL_IDX, gc & 32'hFFFF_FFFE);
		bus(1'b1, GLOBAL_IDX, gc);
		settle(n);
	endtask

	task automatic s_regs();
		do_reset();
		bus(1'b0, GLOBAL_IDX, '0);
		chk(rd, 32'h0000_0000);
		bus(1'b0, STATE_IDX, '0);
		chk(rd[7:0], ORDER_0321);
		bus(1'b0, 6'h3F, '0);
		chk(rd, 32'h0000_0000);
		bus(1'b1, COUNT0_IDX, 32'h0000_0001);
		bus(1'b1, CTRL0_IDX, 32'h0000_0001);
		settle(0);
		chk(gq.size(), 0);
	endtask

	task automatic s_auto();
		run(4'b0001, 32'h0000_0005, 32'h0000_0001, 16'h0003, 3);
		chk(seq(), 16'h0111);
		bus(1'b0, COUNT0_IDX, '0);
		chk(rd[15:0], 16'h0000);
		bus(1'b0, CTRL0_IDX, '0);
		chk(rd, 32'h0000_0007);
		chk(end_irq, 4'h1);
		bus(1'b1, CTRL0_IDX, 32'h0000_0004);
		repeat (3) @(posedge clock);
		chk(end_irq, 4'h0);
	endtask

	task automatic s_prio();
		run(4'b0011, 32'h0000_0001, 32'h0000_0001, 16'h0001, 2);
		chk(seq(), 16'h0012);
		run(4'b0011, 32'h0000_0001, 32'h0000_0101, 16'h0001, 2);
		chk(seq(), 16'h0021);
		run(4'b1011, 32'h0000_0001, 32'h0000_0201, 16'h0001, 3);
		chk(seq(), 16'h0182);
		bus(1'b0, STATE_IDX, '0);
		chk(rd[7:0], 8'h8D);
		run(4'b1011, 32'h0000_0001, 32'h0000_0301, 16'h0001, 3);
		chk(seq(), 16'h0821);
		bus(1'b0, STATE_IDX, '0);
		chk(rd[7:0], ORDER_3210);
		run(4'b0001, 32'h0000_0001, 32'h0000_0301, 16'h0001, 1);
		bus(1'b0, STATE_IDX, '0);
		chk(rd[7:0], ORDER_3210);
	endtask

	task automatic s_abort();
		int n;
		logic [31:0] exp_g[4];
		exp_g = '{32'h0000_0003, 32'h0000_0005, 32'h0000_0001, 32'h0000_0000};
		for (int k = 0; k < 4; k++) begin
			run(4'b0001, 32'h0000_0005, 32'h0000_0001, 16'h0064, 2);
			@(posedge clock);
			nmi  <= (k == 0);
			aerr <= (k == 1);
			@(posedge clock);
			nmi  <= 1'b0;
			aerr <= 1'b0;
			if (k == 2) bus(1'b1, CTRL0_IDX, 32'h0000_0004);
			if (k == 3) bus(1'b1, GLOBAL_IDX, 32'h0000_0000);
			repeat (10) @(posedge clock);
			n = gq.size();
			repeat (40) @(posedge clock);
			chk(gq.size(), n);
			bus(1'b0, GLOBAL_IDX, '0);
			chk(rd, exp_g[k]);
			bus(1'b0, CTRL0_IDX, '0);
			chk(rd[CC_TEF], 1'b0);
			chk(end_irq, 4'h0);
		end
	endtask

	task automatic s_ext();
		for (int s = 0; s < 4; s++) begin
			if (s != 1) begin
				run(4'b0010, 32'h0000_0021 | (s << 8), 32'h0000_0001, 16'h0002, 0);
				u_partner.ext_req(1);
				settle(1);
				chk(seq(), 16'h0002);
				chk(ack_seen, (s == 0) ? 4'h0 : 4'h2);
				chk(dir_seen, (s == 2));
			end
		end
	endtask

	// serial asks burst yet moves one unit; even timers burst, odd timers cycle steal
	task automatic s_chip();
		int u;
		for (int s = 4; s < 12; s++) begin
			u = (s >= 8 && s % 2 == 0) ? 3 : 1;
			run(4'b0100, ((s < 8 || u == 3) ? 32'h0000_0011 : 32'h0000_0001) | (s << 8),
				32'h0000_0001, 16'h0003, 0);
			u_partner.chip_req(4'(s));
			settle(u);
			chk(seq(), (u == 3) ? 16'h0444 : 16'h0004);
			bus(1'b0, COUNT0_IDX + 6'h02, '0);
			chk(rd[15:0], 16'(3 - u));
		end
	endtask

	initial begin
		s_regs();
		s_auto();
		s_prio();
		s_abort();
		s_ext();
		s_chip();
		summarize();
	end

	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		summarize();
	end
endmodule
